// >>> pkg/pio_consts.vh
// Constants for the programmable I/O port block: register offsets, field
// positions, reset values and pin set masks.
// Assumes a byte-wide register port with an 8-bit address and 72 pin lines.
//
// Overview of operation
// - Each port line has one direction bit that decides input or output.
// - A peripheral driving a pin enables its output driver regardless of direction.
// - Input lines read the live pin; writes still update the output latch.
// - Output lines read back the output latch, not the pin.
// - In output mode the latch value is driven onto the pin.
// - One pull-up bit covers four pins, active only on input-direction pins.
// - Pull-up enabling ignores the pin function; only bit and direction count.
// - With latch readback selected, port 1 data reads return the latch always.
// - A three-bit pin set field resets to 000 and picks usable pins.
// - Pin set 011 selects the larger set, 010 the smaller set.
// - While the pin set field holds 000, some pins are not usable.
// - Map bit: serial channel two on port 6 lines 4-7 or port 7 lines 0-3.
// - The pin assignment register is guarded by a protect bit set beforehand.

`ifndef PIO_CONSTS_VH
`define PIO_CONSTS_VH

// Geometry.
`define PIO_NPORT 9
`define PIO_NPIN 72
`define PIO_NGRP 18
`define PIO_NPULL 3

// Register offsets.
`define PIO_DATA_BASE 8'h00
`define PIO_DIR_BASE 8'h10
`define PIO_PULL_BASE 8'h20
`define PIO_READBACK 8'h24
`define PIO_PINASSIGN 8'h25
`define PIO_PROTECT 8'h26

// Field positions.
`define PIO_RB_LATCH_BIT 0
`define PIO_PA_MAP_BIT 3
`define PIO_PR_PA_BIT 2
`define PIO_PA_WMASK 8'h0F
`define PIO_PR_WMASK 8'h04
`define PIO_RB_WMASK 8'h01

// Reset values and encodings.
`define PIO_REG_RST 8'h00
`define PIO_SET_RESET 3'h0
`define PIO_SET_LARGE 3'h3
`define PIO_SET_SMALL 3'h2
`define PIO_LATCH_RB_PORT 4'h1

// Pin set masks, one bit per line; port order 0,1,2,3,6,7,8,9,10.
`define PIO_MASK_LARGE 72'hFFEFFFFFFFFFFFFFFF
`define PIO_MASK_SMALL 72'hFF0FFFFFFF0FFFE00F

// First pin line of each serial channel two placement.
`define PIO_SER_PIN_MAP0 36
`define PIO_SER_PIN_MAP1 40

`endif

// >>> logic/pio_port_block.v
// Programmable I/O port block: direction, latch, pin readback, pull-up groups,
// latch readback control and protected pin assignment control.
// Assumes a byte-wide register port on clk, asynchronous pins on pinIn and
// peripherals that present their own output values and output requests.
`timescale 1ns/100ps
`include "pio_consts.vh"

module pio_port_block (
  input wire clk,
  input wire rst,
  input wire [7:0] regAddr,
  input wire [7:0] regWrData,
  input wire regWr,
  input wire regRd,
  output reg [7:0] regRdData,
  input wire [71:0] pinIn,
  output wire [71:0] pinOut,
  output wire [71:0] pinOe_n,
  output wire [71:0] pullupEn,
  input wire [71:0] periphOut,
  input wire [71:0] periphOe,
  output wire [71:0] periphIn,
  input wire [3:0] serOut,
  input wire [3:0] serOe,
  output wire [3:0] serIn
);

  // ************************************************************
  // Decode helpers
  // ************************************************************

  // True when the address falls inside a per-port register bank.
  function portHit;
    input [7:0] a;
    input [7:0] base;
    begin
      portHit = (a[7:4] == base[7:4]) && (a[3:0] < 4'h9);
    end
  endfunction

  // One-hot port select; all zero when the access misses the bank. Callers
  // only enable it after portHit, so the shift never leaves the nine ports.
  function [8:0] portDecode;
    input en;
    input [3:0] p;
    begin
      portDecode = en ? (9'h001 << p) : 9'h000;
    end
  endfunction

  // Byte of a per-line vector that belongs to one port.
  function [7:0] portByte;
    input [71:0] v;
    input [3:0] p;
    begin
      portByte = v[{p, 3'b000} +: 8];
    end
  endfunction

  // Lines usable under a pin set code; unprogrammed codes keep the small set.
  function [71:0] availMask;
    input [2:0] sel;
    begin
      case (sel)
        `PIO_SET_LARGE: availMask = `PIO_MASK_LARGE;
        `PIO_SET_SMALL: availMask = `PIO_MASK_SMALL;
        default: availMask = `PIO_MASK_SMALL;
      endcase
    end
  endfunction

  // ************************************************************
  // Register state
  // ************************************************************

  reg [71:0] latch_r;
  reg [71:0] dir_r;
  reg [23:0] pull_r;
  reg [7:0] readback_r;
  reg [7:0] pinAssign_r;
  reg [7:0] protect_r;
  reg [71:0] sync1_r;
  reg [71:0] sync2_r;
  reg [71:0] sync3_r;
  reg [71:0] pinStable_r;
  reg [7:0] rdData_nxt;
  reg [71:0] pinStable_nxt;
  wire [71:0] avail;
  wire [71:0] serOeMap;
  wire [71:0] serOutMap;
  wire [71:0] driveOe;
  wire [71:0] periphDrive;
  wire [71:0] periphVal;
  wire [71:0] latch_nxt;
  wire [71:0] dir_nxt;
  wire [8:0] dataWrEn;
  wire [8:0] dirWrEn;
  wire [17:0] pullGroups;
  wire [2:0] pinSet;
  wire serMap;
  wire latchReadback;
  wire paUnlocked;
  wire [3:0] portSel;

  assign pinSet = pinAssign_r[2:0];
  assign serMap = pinAssign_r[`PIO_PA_MAP_BIT];
  assign latchReadback = readback_r[`PIO_RB_LATCH_BIT];
  assign paUnlocked = protect_r[`PIO_PR_PA_BIT];
  assign portSel = regAddr[3:0];
  assign pullGroups = pull_r[17:0];

  // ************************************************************
  // Per-port latch and direction registers
  // ************************************************************

  // A write selects at most one port of each bank.
  assign dataWrEn = portDecode(regWr && portHit(regAddr, `PIO_DATA_BASE), portSel);
  assign dirWrEn = portDecode(regWr && portHit(regAddr, `PIO_DIR_BASE), portSel);

  // Next values per port; the latch takes every write, whatever the direction
  // of each line, so an input line has the right value ready when it turns.
  genvar k;
  generate
    for (k = 0; k < `PIO_NPORT; k = k + 1) begin : gPort
      assign latch_nxt[k*8 +: 8] = dataWrEn[k] ? regWrData : latch_r[k*8 +: 8];
      assign dir_nxt[k*8 +: 8] = dirWrEn[k] ? regWrData : dir_r[k*8 +: 8];
    end
  endgenerate

  // Direction bits reset to input so no latch value is driven before software acts.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      latch_r <= {`PIO_NPORT{`PIO_REG_RST}};
      dir_r <= {`PIO_NPORT{`PIO_REG_RST}};
    end else begin
      latch_r <= latch_nxt;
      dir_r <= dir_nxt;
    end
  end

  // ************************************************************
  // Control registers
  // ************************************************************

  // Pull-up groups, readback control and the protect register write freely.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pull_r <= {`PIO_NPULL{`PIO_REG_RST}};
      readback_r <= `PIO_REG_RST;
      protect_r <= `PIO_REG_RST;
    end else if (regWr) begin
      if (regAddr == `PIO_PULL_BASE) begin
        pull_r[7:0] <= regWrData;
      end
      if (regAddr == `PIO_PULL_BASE + 8'h01) begin
        pull_r[15:8] <= regWrData;
      end
      if (regAddr == `PIO_PULL_BASE + 8'h02) begin
        pull_r[23:16] <= {6'h00, regWrData[1:0]};
      end
      if (regAddr == `PIO_READBACK) begin
        readback_r <= regWrData & `PIO_RB_WMASK;
      end
      if (regAddr == `PIO_PROTECT) begin
        protect_r <= regWrData & `PIO_PR_WMASK;
      end
    end
  end

  // Pin assignment only changes while unlocked; a locked write leaves it intact.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pinAssign_r <= {5'h00, `PIO_SET_RESET};
    end else if (regWr && (regAddr == `PIO_PINASSIGN)) begin
      if (paUnlocked) begin
        pinAssign_r <= regWrData & `PIO_PA_WMASK;
      end else begin
        pinAssign_r <= pinAssign_r;
      end
    end
  end

  // ************************************************************
  // Pin input synchroniser
  // ************************************************************

  // Three stages; a line only changes once the second and third stages agree.
  always @* begin
    pinStable_nxt = (sync2_r & sync3_r) | (pinStable_r & (sync2_r | sync3_r));
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_r <= {`PIO_NPIN{1'b0}};
      sync2_r <= {`PIO_NPIN{1'b0}};
      sync3_r <= {`PIO_NPIN{1'b0}};
      pinStable_r <= {`PIO_NPIN{1'b0}};
    end else begin
      sync1_r <= pinIn;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      pinStable_r <= pinStable_nxt;
    end
  end

  // Peripherals see the filtered pin; they rely on software setting input mode.
  assign periphIn = pinStable_r;

  // ************************************************************
  // Serial channel two routing
  // ************************************************************

  // Handshake, clock, receive and transmit occupy four adjacent lines.
  assign serIn = serMap ? pinStable_r[`PIO_SER_PIN_MAP1 +: 4] :
                          pinStable_r[`PIO_SER_PIN_MAP0 +: 4];

  generate
    for (k = 0; k < `PIO_NPIN; k = k + 1) begin : gSer
      if ((k >= `PIO_SER_PIN_MAP0) && (k < `PIO_SER_PIN_MAP0 + 4)) begin : gLo
        assign serOeMap[k] = ~serMap & serOe[k - `PIO_SER_PIN_MAP0];
        assign serOutMap[k] = serOut[k - `PIO_SER_PIN_MAP0];
      end else if ((k >= `PIO_SER_PIN_MAP1) && (k < `PIO_SER_PIN_MAP1 + 4)) begin : gHi
        assign serOeMap[k] = serMap & serOe[k - `PIO_SER_PIN_MAP1];
        assign serOutMap[k] = serOut[k - `PIO_SER_PIN_MAP1];
      end else begin : gNone
        assign serOeMap[k] = 1'b0;
        assign serOutMap[k] = 1'b0;
      end
    end
  endgenerate

  // ************************************************************
  // Pin drivers and pull-ups
  // ************************************************************

  // Lines outside the active pin set stay undriven; until software picks a set the small set applies.
  assign avail = availMask(pinSet);

  // Any peripheral drive request on a line, generic or serial channel two.
  assign periphDrive = periphOe | serOeMap;
  assign periphVal = (periphOut & periphOe) | (serOutMap & serOeMap);

  // A peripheral output request overrides the direction bit. Lines outside the
  // active pin set never drive, so a wrong pin set cannot fight the board.
  assign driveOe = avail & (periphDrive | dir_r);
  assign pinOe_n = ~driveOe;

  // Per-bit select: the peripheral value where it drives, the latch elsewhere.
  assign pinOut = periphVal | (latch_r & ~periphDrive);

  // Pull-up group g covers lines 4g to 4g+3, only while they are inputs.
  generate
    for (k = 0; k < `PIO_NPIN; k = k + 1) begin : gPull
      assign pullupEn[k] = pullGroups[k / 4] & ~dir_r[k];
    end
  endgenerate

  // ************************************************************
  // Register read path
  // ************************************************************

  // Read value for the addressed register; unmapped addresses read zero.
  always @* begin
    rdData_nxt = 8'h00;
    if (portHit(regAddr, `PIO_DATA_BASE)) begin
      if (latchReadback && (portSel == `PIO_LATCH_RB_PORT)) begin
        rdData_nxt = portByte(latch_r, portSel);
      end else begin
        // Output lines return the latch, input lines the filtered pin.
        rdData_nxt = (portByte(dir_r, portSel) & portByte(latch_r, portSel)) |
                     (~portByte(dir_r, portSel) & portByte(pinStable_r, portSel));
      end
    end else if (portHit(regAddr, `PIO_DIR_BASE)) begin
      rdData_nxt = portByte(dir_r, portSel);
    end else if (regAddr == `PIO_PULL_BASE) begin
      rdData_nxt = pull_r[7:0];
    end else if (regAddr == `PIO_PULL_BASE + 8'h01) begin
      rdData_nxt = pull_r[15:8];
    end else if (regAddr == `PIO_PULL_BASE + 8'h02) begin
      rdData_nxt = pull_r[23:16];
    end else if (regAddr == `PIO_READBACK) begin
      rdData_nxt = readback_r;
    end else if (regAddr == `PIO_PINASSIGN) begin
      rdData_nxt = pinAssign_r;
    end else if (regAddr == `PIO_PROTECT) begin
      rdData_nxt = protect_r;
    end
  end

  // Read data stand for exactly the cycle after the strobe, zero otherwise.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      regRdData <= 8'h00;
    end else if (regRd) begin
      regRdData <= rdData_nxt;
    end else begin
      regRdData <= 8'h00;
    end
  end

endmodule // pio_port_block

// >>> bench/pio_port_block_monitor.sv
// Checker for the programmable I/O port block, bound to its top module.
// Assumes one clock, async active-high reset and the byte register map.
`timescale 1ns/100ps
module pio_port_block_monitor (
  input wire clk,
  input wire rst,
  input wire [7:0] regAddr,
  input wire [7:0] regWrData,
  input wire regWr,
  input wire regRd,
  input wire [7:0] regRdData,
  input wire [71:0] pinOut,
  input wire [71:0] pinOe_n,
  input wire [71:0] pullupEn,
  input wire [71:0] periphOut,
  input wire [71:0] periphOe,
  input wire [3:0] serOut,
  input wire [3:0] serOe
);
  // ****************************************
  // Shadow registers
  // ****************************************
  reg [7:0] lat0_r, lat1_r, dir0_r;
  reg [3:0] pa_r;
  reg rb_r, prot_r, pl0_r;
  // Kept from the bus alone, so a register that never updates is caught.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      {lat0_r, lat1_r, dir0_r, pa_r, rb_r, prot_r, pl0_r} <= 31'h0;
    end else if (regWr) begin
      case (regAddr)
        8'h00: lat0_r <= regWrData;
        8'h01: lat1_r <= regWrData;
        8'h10: dir0_r <= regWrData;
        8'h20: pl0_r <= regWrData[0];
        8'h24: rb_r <= regWrData[0];
        8'h25: if (prot_r) pa_r <= regWrData[3:0];
        8'h26: prot_r <= regWrData[2];
        default: ;
      endcase
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  AST_OUT_DRIVE: assert property (dir0_r[0] && !periphOe[0] |->
    !pinOe_n[0] && pinOut[0] == lat0_r[0]) else $error("latch not on output pin");
  AST_IN_FLOAT: assert property (!dir0_r[0] && !periphOe[0] |-> pinOe_n[0])
    else $error("input line driven");
  AST_PERIPH_WINS: assert property (periphOe[1] |->
    !pinOe_n[1] && pinOut[1] == periphOut[1]) else $error("peripheral drive lost");
  AST_PULL_INPUT: assert property (pullupEn[3:0] == ({4{pl0_r}} & ~dir0_r[3:0]))
    else $error("pull-up group zero wrong");
  AST_PULL_ANYFUNC: assert property ($rose(periphOe[1]) && !$past(regWr) |->
    $stable(pullupEn[1])) else $error("pull-up follows function");
  AST_OUT_READ: assert property (regRd && regAddr == 8'h00 && dir0_r[0] |=>
    regRdData[0] == lat0_r[0]) else $error("output line read not latch");
  AST_LATCH_RB: assert property (regRd && regAddr == 8'h01 && rb_r |=>
    regRdData == lat1_r) else $error("latch readback wrong");
  AST_PA_GUARD: assert property (regRd && regAddr == 8'h25 |=>
    regRdData == {4'h0, pa_r}) else $error("pin assign content wrong");
  AST_SER_MAP: assert property (serOe[3] |-> !pinOe_n[pa_r[3] ? 43 : 39] &&
    pinOut[pa_r[3] ? 43 : 39] == serOut[3]) else $error("serial map wrong");
  // Main scenarios reached.
  cover property (regRd && regAddr == 8'h01 && rb_r);
  cover property (serOe[3] && pa_r[3]);
  cover property (regWr && regAddr == 8'h25 && !prot_r);
endmodule // pio_port_block_monitor
bind pio_port_block pio_port_block_monitor u_mon (.clk(clk), .rst(rst), .regAddr(regAddr),
  .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
  .pinOut(pinOut), .pinOe_n(pinOe_n), .pullupEn(pullupEn), .periphOut(periphOut),
  .periphOe(periphOe), .serOut(serOut), .serOe(serOe));

// >>> bench/pio_pin_env.sv
// Pin environment: resolves each pad from device drive, outside drive, pull-up.
// Assumes the device enable is active low and outside drivers are weaker.
`timescale 1ns/100ps
module pio_pin_env (
  input wire [71:0] pinOut,
  input wire [71:0] pinOe_n,
  input wire [71:0] pullupEn,
  input wire [71:0] extLvl,
  input wire [71:0] extDrv,
  output wire [71:0] pinLvl
);
  // A floating pad without pull-up shows the inverse of the device output, so a stale
  // level can never pass for a driven one.
  assign pinLvl = (~pinOe_n & pinOut) | (pinOe_n & extDrv & extLvl)
    | (pinOe_n & ~extDrv & (pullupEn | ~pinOut));
endmodule // pio_pin_env

// >>> bench/pio_port_block_test.sv
// Self-checking bench for the programmable I/O port block.
// Assumes the byte register map and a 3-4 edge pin filter.
`timescale 1ns/100ps
module pio_port_block_test;
  // ****************************************
  // Signals and instances
  // ****************************************
  reg clk = 1'b0, rst = 1'b1, regWr = 1'b0, regRd = 1'b0, rdPend = 1'b0;
  reg [7:0] regAddr = 8'h00, regWrData = 8'h00;
  reg [71:0] periphOut = 72'h0, periphOe = 72'h0, extLvl = 72'h0, extDrv = {72{1'b1}};
  reg [3:0] serOut = 4'h0, serOe = 4'h0;
  reg [31:0] seed = 32'h716F2C44;
  wire [7:0] regRdData;
  wire [71:0] pinOut, pinOe_n, pullupEn, pinLvl, periphIn;
  wire [3:0] serIn;
  reg [7:0] expQ[$];
  integer failures = 0, numChecks = 0, i;
  always #2.5 clk = ~clk;
  pio_port_block dut (.clk(clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .pinIn(pinLvl), .pinOut(pinOut),
    .pinOe_n(pinOe_n), .pullupEn(pullupEn), .periphOut(periphOut), .periphOe(periphOe),
    .periphIn(periphIn), .serOut(serOut), .serOe(serOe), .serIn(serIn));
  pio_pin_env env (.pinOut(pinOut), .pinOe_n(pinOe_n), .pullupEn(pullupEn),
    .extLvl(extLvl), .extDrv(extDrv), .pinLvl(pinLvl));
  // ****************************************
  // Tasks
  // ****************************************
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task chk(input [71:0] seen, input [71:0] exp);
    begin
      numChecks = numChecks + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  // Strobes stand from one edge to the next; pause drops them.
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge clk);
      regWr <= 1'b1;
      regRd <= 1'b0;
      regAddr <= a;
      regWrData <= d;
    end
  endtask
  task rd(input [7:0] a, input [7:0] e);
    begin
      @(posedge clk);
      expQ.push_back(e);
      regRd <= 1'b1;
      regWr <= 1'b0;
      regAddr <= a;
    end
  endtask
  task pause(input integer n);
    begin
      @(posedge clk);
      regWr <= 1'b0;
      regRd <= 1'b0;
      repeat (n) @(posedge clk);
      #1;
    end
  endtask
  task wrap_up;
    begin
      $display("checks=%0d failures=%0d", numChecks, failures);
      if (failures == 0 && numChecks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
    end
  endtask
  // Read data stand only in the cycle after the strobe, so look mid-cycle.
  always @(posedge clk) rdPend <= regRd;
  always @(negedge clk) if (rdPend && !rst) chk(regRdData, expQ.pop_front());
  initial begin
    repeat (5000) @(posedge clk);
    failures = failures + 1;
    wrap_up;
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd(8'h25, 8'h00);
    rd(8'h30, 8'h00);
    wr(8'h25, 8'h03);
    rd(8'h25, 8'h00);
    wr(8'h26, 8'h04);
    wr(8'h25, 8'h0B);
    rd(8'h25, 8'h0B);
    wr(8'h10, 8'h0F);
    rd(8'h10, 8'h0F);
    for (i = 0; i < 4; i = i + 1) begin
      seed = lfsr(lfsr(seed));
      wr(8'h00, seed[7:0]);
      extLvl[7:0] <= seed[15:8];
      pause(6);
      chk(pinOut[3:0], seed[3:0]);
      rd(8'h00, {seed[15:12], seed[3:0]});
    end
    wr(8'h11, 8'h00);
    wr(8'h01, 8'hA5);
    extLvl[15:8] <= 8'h5A;
    pause(6);
    chk(periphIn[15:8], 8'h5A);
    rd(8'h01, 8'h5A);
    wr(8'h24, 8'h01);
    rd(8'h01, 8'hA5);
    wr(8'h10, 8'h05);
    wr(8'h20, 8'h01);
    pause(1);
    chk(pullupEn[3:0], 4'hA);
    @(posedge clk);
    periphOe[1] <= 1'b1;
    periphOut[1] <= 1'b1;
    serOe <= 4'hF;
    serOut <= 4'hA;
    pause(6);
    chk(pullupEn[3:0], 4'hA);
    chk({pinOe_n[1], pinOut[1]}, 2'b01);
    chk({pinOe_n[43:40], pinOut[43:40]}, 8'h0A);
    wr(8'h25, 8'h03);
    pause(6);
    chk({pinOut[39:36], serIn}, 8'hAA);
    @(posedge clk);
    serOe <= 4'h0;
    periphOe <= 72'h0;
    rst <= 1'b1;
    pause(2);
    chk(pinOe_n, {72{1'b1}});
    @(posedge clk);
    rst <= 1'b0;
    rd(8'h25, 8'h00);
    wr(8'h10, 8'hF0);
    pause(1);
    chk(pinOe_n[7:0], 8'hFF);
    wr(8'h26, 8'h04);
    wr(8'h25, 8'h02);
    pause(1);
    chk(pinOe_n[7:0], 8'hFF);
    wr(8'h25, 8'h03);
    pause(1);
    chk(pinOe_n[7:0], 8'h0F);
    pause(3);
    wrap_up;
  end
endmodule // pio_port_block_test
